// ### core/vcr_regs.sv
`timescale 1ns/1ps
// Configuration and message registers shared by bus host and processor.
module vcr_regs #(
   parameter logic [15:0] PROTOCOL_CAPS = vcr_pkg::PROTOCOL_DEFAULT,
   parameter int          DEPTH         = vcr_pkg::FIFO_DEPTH
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        host_sel_i,
   input  wire logic        host_wr_i,
   input  wire logic [5:0]  host_addr_i,
   input  wire logic [15:0] host_wdata_i,
   output logic      [15:0] host_rdata_o,
   input  wire logic        proc_sel_i,
   input  wire logic        proc_wr_i,
   input  wire logic [5:0]  proc_addr_i,
   input  wire logic [15:0] proc_wdata_i,
   output logic      [15:0] proc_rdata_o,
   input  wire logic        ident_asserted_i,
   output logic             cmd_valid_o,
   input  wire logic        cmd_ready_i,
   output logic      [15:0] cmd_data_o,
   output logic             ext_space_access_enable_o,
   output logic      [15:0] space_offset_o,
   output logic             sysfail_inhibit_o,
   output logic             carrier_reset_o
);
   logic [15:0] resp, next_resp, data_word, next_data_word;
   logic [15:0] offset, next_offset, next_host_rdata, next_proc_rdata;
   logic [3:0]  selftest_result_code, next_result;
   logic        ready, next_ready, pass, next_pass;
   logic        access_en, next_access_en, sf_inh, next_sf_inh;
   logic        rst_req, next_rst_req;
   logic        hw_status, hw_data, hr_data, pw_data, pw_resp, pw_stat;
   logic        fifo_ready, fifo_valid, cmd_v, next_cmd_v;
   logic [15:0] fifo_data, cmd_d, next_cmd_d, status_word;
   logic        hw_offset;
   // Response bits the processor may write: its own bits and both flags.
   localparam logic [15:0] RESP_WRITABLE = vcr_pkg::RESP_PROC_MASK
      | (16'h0001 << vcr_pkg::BIT_READ_READY)
      | (16'h0001 << vcr_pkg::BIT_WRITE_READY);

   // Host data writes queue toward the handler; a full queue drops none
   // because write_ready is held low while the queue is full.
   vcr_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (hw_data),
      .in_ready_o  (fifo_ready),
      .in_data_i   (host_wdata_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (!cmd_v || cmd_ready_i),
      .out_data_o  (fifo_data)
   );

   // Status word: bit 14 reads zero while the identify line is asserted.
   always_comb begin
      status_word = '0;
      status_word[vcr_pkg::BIT_ACCESS_EN] = access_en;
      status_word[vcr_pkg::BIT_IDENT] = !ident_asserted_i;
      status_word[vcr_pkg::BIT_RESULT_LO+:4] = selftest_result_code;
      status_word[vcr_pkg::BIT_READY] = ready;
      status_word[vcr_pkg::BIT_PASS]  = pass;
   end

   // Access decode for both sides.
   always_comb begin
      hw_status = host_sel_i && host_wr_i
                  && host_addr_i == vcr_pkg::OFS_STATUS_CONTROL;
      hw_data   = host_sel_i && host_wr_i
                  && host_addr_i == vcr_pkg::OFS_DATA_WORD;
      hr_data   = host_sel_i && !host_wr_i
                  && host_addr_i == vcr_pkg::OFS_DATA_WORD;
      pw_data   = proc_sel_i && proc_wr_i
                  && proc_addr_i == vcr_pkg::OFS_DATA_WORD;
      pw_resp   = proc_sel_i && proc_wr_i
                  && proc_addr_i == vcr_pkg::OFS_RESPONSE;
      pw_stat   = proc_sel_i && proc_wr_i
                  && proc_addr_i == vcr_pkg::OFS_STATUS_CONTROL;
      hw_offset = host_sel_i && host_wr_i
                  && host_addr_i == vcr_pkg::OFS_SPACE_OFFSET;
   end

   // Host control group. Only the bus host reaches these bits; processor
   // writes to the space offset are not decoded, and processor writes to the
   // status offset load only its own bits, which keeps the host-only
   // fields out of the processor's reach. No side decodes protocol writes.
   always_comb begin
      next_access_en = access_en;
      next_sf_inh    = sf_inh;
      next_rst_req   = 1'b0;
      next_offset    = offset;
      if (hw_status) begin
         next_access_en = host_wdata_i[vcr_pkg::BIT_ACCESS_EN];
         next_sf_inh    = host_wdata_i[vcr_pkg::BIT_SYSFAIL_INH];
         next_rst_req   = host_wdata_i[vcr_pkg::BIT_RESET];
      end
      if (hw_offset) begin
         next_offset = host_wdata_i;
      end
   end

   // The reset request lasts one cycle per write; whatever resets the
   // carrier must stretch it if it needs a longer pulse.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         access_en <= 1'b0;
         sf_inh    <= 1'b0;
         rst_req   <= 1'b0;
         offset    <= vcr_pkg::OFFSET_RESET;
      end else begin
         access_en <= next_access_en;
         sf_inh    <= next_sf_inh;
         rst_req   <= next_rst_req;
         offset    <= next_offset;
      end
   end

   // Processor status group: self-test code, ready and pass. Host writes
   // to these bits are ignored, so the host cannot fake a passed test.
   always_comb begin
      next_result = selftest_result_code;
      next_ready  = ready;
      next_pass   = pass;
      if (pw_stat) begin
         next_result = proc_wdata_i[vcr_pkg::BIT_RESULT_LO+:4];
         next_ready  = proc_wdata_i[vcr_pkg::BIT_READY];
         next_pass   = proc_wdata_i[vcr_pkg::BIT_PASS];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         selftest_result_code <= vcr_pkg::RESULT_RESET;
         ready                <= 1'b0;
         pass                 <= 1'b0;
      end else begin
         selftest_result_code <= next_result;
         ready                <= next_ready;
         pass                 <= next_pass;
      end
   end

   // Response bits, one slice per bit. The processor writes the bits it
   // owns; a host access that empties or fills the data word clears the
   // matching ready flag, and that clear beats a processor set in the same
   // cycle so a stale flag never invites a second transfer. Write ready is
   // also held low while the queue is full, as a word written then would
   // be lost.
   for (genvar i = 0; i < 16; i++) begin : g_resp
      logic clear, load;
      assign clear = (i == vcr_pkg::BIT_READ_READY && hr_data)
                     || (i == vcr_pkg::BIT_WRITE_READY
                         && (hw_data || !fifo_ready));
      assign load  = pw_resp && RESP_WRITABLE[i];
      assign next_resp[i] = clear ? 1'b0
                            : load ? proc_wdata_i[i] : resp[i];
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         resp <= vcr_pkg::RESP_RESET;
      end else begin
         resp <= next_resp;
      end
   end

   // Data word group. Either side may write; when both write in one cycle
   // the host word is kept, as it is also the one queued for the handler.
   always_comb begin
      next_data_word = data_word;
      if (pw_data) begin
         next_data_word = proc_wdata_i;
      end
      if (hw_data) begin
         next_data_word = host_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         data_word <= '0;
      end else begin
         data_word <= next_data_word;
      end
   end

   // Command stage toward the word serial handler. A word stands on the
   // outputs until the handler takes it; the queue refills the stage in
   // the cycle of a take, so a busy handler loses no throughput.
   always_comb begin
      next_cmd_v = cmd_v && !cmd_ready_i;
      next_cmd_d = cmd_d;
      if (fifo_valid && (!cmd_v || cmd_ready_i)) begin
         next_cmd_v = 1'b1;
         next_cmd_d = fifo_data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cmd_v <= 1'b0;
         cmd_d <= '0;
      end else begin
         cmd_v <= next_cmd_v;
         cmd_d <= next_cmd_d;
      end
   end

   // Host read mux. Unmapped offsets read zero; the mux runs whether or
   // not the host selects, which keeps the select out of the data path.
   always_comb begin
      unique case (host_addr_i)
         vcr_pkg::OFS_STATUS_CONTROL: next_host_rdata = status_word;
         vcr_pkg::OFS_SPACE_OFFSET:   next_host_rdata = offset;
         vcr_pkg::OFS_PROTOCOL:       next_host_rdata = PROTOCOL_CAPS;
         vcr_pkg::OFS_RESPONSE:       next_host_rdata = resp;
         vcr_pkg::OFS_DATA_WORD:      next_host_rdata = data_word;
         default:                     next_host_rdata = '0;
      endcase
   end

   // Processor read mux; the processor sees the same words as the host,
   // including the offset that it may not write.
   always_comb begin
      unique case (proc_addr_i)
         vcr_pkg::OFS_STATUS_CONTROL: next_proc_rdata = status_word;
         vcr_pkg::OFS_SPACE_OFFSET:   next_proc_rdata = offset;
         vcr_pkg::OFS_PROTOCOL:       next_proc_rdata = PROTOCOL_CAPS;
         vcr_pkg::OFS_RESPONSE:       next_proc_rdata = resp;
         vcr_pkg::OFS_DATA_WORD:      next_proc_rdata = data_word;
         default:                     next_proc_rdata = '0;
      endcase
   end

   // Read data is registered, so both sides see the answer one cycle after
   // the select edge and every output comes straight from a flip-flop.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         host_rdata_o <= '0;
         proc_rdata_o <= '0;
      end else begin
         host_rdata_o <= next_host_rdata;
         proc_rdata_o <= next_proc_rdata;
      end
   end

   assign cmd_valid_o               = cmd_v;
   assign cmd_data_o                = cmd_d;
   assign ext_space_access_enable_o = access_en;
   assign space_offset_o            = offset;
   assign sysfail_inhibit_o         = sf_inh;
   assign carrier_reset_o           = rst_req;
endmodule // vcr_regs

// ### core/vcr_pkg.sv
package vcr_pkg;
   localparam logic [5:0]  OFS_STATUS_CONTROL = 6'h04;
   localparam logic [5:0]  OFS_SPACE_OFFSET   = 6'h06;
   localparam logic [5:0]  OFS_PROTOCOL       = 6'h08;
   localparam logic [5:0]  OFS_RESPONSE       = 6'h0a;
   localparam logic [5:0]  OFS_DATA_WORD      = 6'h0e;
   localparam int          BIT_ACCESS_EN      = 15;
   localparam int          BIT_IDENT          = 14;
   localparam int          BIT_RESULT_LO      = 4;
   localparam int          BIT_READY          = 3;
   localparam int          BIT_PASS           = 2;
   localparam int          BIT_SYSFAIL_INH    = 1;
   localparam int          BIT_RESET          = 0;
   localparam int          BIT_READ_READY     = 10;
   localparam int          BIT_WRITE_READY    = 9;
   // Response bits the processor owns besides the two ready flags.
   localparam logic [15:0] RESP_PROC_MASK     = 16'h3980;
   localparam logic [15:0] RESP_RESET         = 16'h3980;
   localparam logic [15:0] PROTOCOL_DEFAULT   = 16'hfc00;
   localparam logic [3:0]  RESULT_RESET       = 4'h0;
   localparam logic [15:0] OFFSET_RESET       = 16'h0000;
   localparam int          FIFO_DEPTH         = 4;
endpackage : vcr_pkg

// ### core/vcr_fifo.sv
`timescale 1ns/1ps
// Small FIFO carrying host-written data words toward the word serial handler.
module vcr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   // Pointer and count update; full and empty come from the count.
   // Pointers wrap at the last entry, so a depth that is not a power of
   // two works as well.
   always_comb begin
      push        = in_valid_i && in_ready_o;
      pop         = out_ready_i && out_valid_o;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push) begin
         next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + AW'(1);
      end
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage needs no reset; it is only read when the count says valid.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
endmodule // vcr_fifo

// ### test/vcr_regs_assertions.sv
`timescale 1ns/1ps
// Port-level checks on the shared register bank.
module vcr_chk #(
   parameter logic [15:0] PROTOCOL_CAPS = 16'hfc00
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        host_sel_i,
   input wire logic        host_wr_i,
   input wire logic [5:0]  host_addr_i,
   input wire logic [15:0] host_wdata_i,
   input wire logic [15:0] host_rdata_o,
   input wire logic        ident_asserted_i,
   input wire logic        cmd_valid_o,
   input wire logic        cmd_ready_i,
   input wire logic [15:0] cmd_data_o,
   input wire logic        ext_space_access_enable_o,
   input wire logic [15:0] space_offset_o,
   input wire logic        sysfail_inhibit_o,
   input wire logic        carrier_reset_o
);
   logic hr, hw, stw, rq;
   // Decoded host strobes keep the properties short.
   assign hr = host_sel_i & ~host_wr_i;
   assign hw = host_sel_i & host_wr_i;
   assign stw = hw & (host_addr_i == 6'h04);
   assign rq = stw & host_wdata_i[0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_rd(a); hr && host_addr_i == a; endsequence
   sequence s_wr(a); hw && host_addr_i == a; endsequence
   property p_proto; s_rd(6'h08) |=> host_rdata_o == PROTOCOL_CAPS; endproperty
   a_proto: assert property (p_proto) else $error("protocol read bad");
   property p_rst; rq |=> carrier_reset_o; endproperty
   a_rst: assert property (p_rst) else $error("no reset pulse");
   property p_rsrc; carrier_reset_o |-> $past(rq); endproperty
   a_rsrc: assert property (p_rsrc) else $error("stray reset pulse");
   property p_ctl; stw |=> ext_space_access_enable_o == $past(host_wdata_i[15])
      && sysfail_inhibit_o == $past(host_wdata_i[1]); endproperty
   a_ctl: assert property (p_ctl) else $error("control bits bad");
   property p_off; s_wr(6'h06) |=> space_offset_o == $past(host_wdata_i);
   endproperty
   a_off: assert property (p_off) else $error("offset not loaded");
   property p_cmd; s_wr(6'h0e) |-> ##[1:3] cmd_valid_o; endproperty
   a_cmd: assert property (p_cmd) else $error("handler not told");
   property p_hold; cmd_valid_o && !cmd_ready_i |=> cmd_valid_o
      && $stable(cmd_data_o); endproperty
   a_hold: assert property (p_hold) else $error("command word lost");
   property p_read_ready_flag; s_rd(6'h0e) ##1 s_rd(6'h0a) |=> !host_rdata_o[10];
   endproperty
   a_read_ready_flag: assert property (p_read_ready_flag) else $error("read ready kept");
   property p_write_ready_flag; s_wr(6'h0e) ##1 s_rd(6'h0a) |=> !host_rdata_o[9];
   endproperty
   a_write_ready_flag: assert property (p_write_ready_flag) else $error("write ready kept");
   property p_id; s_rd(6'h04) ##0 ident_asserted_i |=> !host_rdata_o[14];
   endproperty
   a_id: assert property (p_id) else $error("identify bit bad");
endmodule // vcr_chk

bind vcr_regs vcr_chk #(.PROTOCOL_CAPS(PROTOCOL_CAPS)) u_chk (.clk_i,
   .rst_n_i, .host_sel_i, .host_wr_i, .host_addr_i, .host_wdata_i,
   .host_rdata_o, .ident_asserted_i, .cmd_valid_o, .cmd_ready_i, .cmd_data_o,
   .ext_space_access_enable_o, .space_offset_o, .sysfail_inhibit_o,
   .carrier_reset_o);

// ### test/vcr_bus_model.sv
`timescale 1ns/1ps
// Bus master standing in for the bus host or the processor port.
module vcr_bus_model (
   input  wire logic        clk_i,
   output logic             sel_o = 1'b0,
   output logic             wr_o = 1'b0,
   output logic      [5:0]  addr_o = 6'h00,
   output logic      [15:0] wdata_o = 16'h0000,
   input  wire logic [15:0] rdata_i
);
   // One access per call from a falling edge; the strobe stays up when
   // another access follows, so it is never driven twice in one step.
   task automatic acc(input logic w, input logic [5:0] a,
      input logic [15:0] d, input bit more, output logic [15:0] q);
      sel_o = 1'b1;
      wr_o = w;
      addr_o = a;
      wdata_o = d;
      @(negedge clk_i);
      q = rdata_i;
      if (!more) begin
         sel_o = 1'b0;
         wdata_o = ~wdata_o; // A released bus shows no stale word.
         @(negedge clk_i);
      end
   endtask
   // Host side of the word handshake: data goes only once write ready.
   task automatic send(input logic [15:0] d, output bit ok,
      output logic [15:0] q);
      ok = 1'b0;
      for (int i = 0; i < 8 && !ok; i++) begin
         acc(1'b0, 6'h0a, 16'h0000, 1'b1, q);
         ok = q[9];
      end
      if (ok) acc(1'b1, 6'h0e, d, 1'b1, q);
      acc(1'b0, 6'h0a, 16'h0000, 1'b0, q);
   endtask
endmodule // vcr_bus_model

// ### test/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the shared register bank.
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        ident_asserted_i = 1'b0;
   logic        cmd_ready_i = 1'b0;
   logic        hs, hw, ps, pw, cv, aen, sfi, crst;
   logic [5:0]  ha, pa;
   logic [15:0] hd, hq, pd, pq, cd, ofs, q, v;
   logic [31:0] r;
   logic [15:0] sent[$];
   int          errors = 0;
   int          n_compared = 0;
   int          seed = 13;
   int          n, t;
   bit          ok;
   always #4 clk_i = ~clk_i;
   vcr_bus_model host (.clk_i, .sel_o(hs), .wr_o(hw), .addr_o(ha),
      .wdata_o(hd), .rdata_i(hq));
   vcr_bus_model proc (.clk_i, .sel_o(ps), .wr_o(pw), .addr_o(pa),
      .wdata_o(pd), .rdata_i(pq));
   vcr_regs DUT (.clk_i, .rst_n_i, .host_sel_i(hs), .host_wr_i(hw),
      .host_addr_i(ha), .host_wdata_i(hd), .host_rdata_o(hq),
      .proc_sel_i(ps), .proc_wr_i(pw), .proc_addr_i(pa), .proc_wdata_i(pd),
      .proc_rdata_o(pq), .ident_asserted_i, .cmd_valid_o(cv), .cmd_ready_i,
      .cmd_data_o(cd), .ext_space_access_enable_o(aen),
      .space_offset_o(ofs), .sysfail_inhibit_o(sfi), .carrier_reset_o(crst));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic conclude;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Status read: host bit 15, identify inverted, processor bits 7 to 2.
   function automatic logic [15:0] stat(logic [31:0] x);
      return {x[7], ~x[6], 6'h00, x[5:0], 2'b00};
   endfunction
   // A hung handshake still ends in the verdict.
   initial begin
      #400000;
      errors++;
      conclude();
   end
   // Directed corners first, then random status, offset and word traffic.
   initial begin
      repeat (4) @(negedge clk_i);
      rst_n_i = 1'b1;
      host.acc(1'b0, 6'h0a, 16'h0000, 1'b0, q);
      chk(q, vcr_pkg::RESP_RESET);
      host.acc(1'b1, 6'h0a, 16'h0000, 1'b0, q);
      host.acc(1'b1, 6'h08, 16'h0000, 1'b0, q);
      proc.acc(1'b1, 6'h08, 16'h0000, 1'b0, q);
      host.acc(1'b0, 6'h0a, 16'h0000, 1'b1, q);
      chk(q, vcr_pkg::RESP_RESET);
      host.acc(1'b0, 6'h08, 16'h0000, 1'b1, q);
      chk(q, vcr_pkg::PROTOCOL_DEFAULT);
      host.acc(1'b0, 6'h0c, 16'h0000, 1'b0, q);
      chk(q, 16'h0000);
      proc.acc(1'b0, 6'h08, 16'h0000, 1'b0, q);
      chk(q, vcr_pkg::PROTOCOL_DEFAULT);
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         ident_asserted_i = r[6];
         proc.acc(1'b1, 6'h04, {~r[7], 7'h00, r[5:0], 2'b11}, 1'b0, q);
         proc.acc(1'b1, 6'h06, r[31:16], 1'b0, q);
         host.acc(1'b1, 6'h04, {r[7], 7'h7f, ~r[5:0], r[8], r[9]}, 1'b1, q);
         chk(crst, r[9]);
         host.acc(1'b1, 6'h06, r[15:0], 1'b1, q);
         chk(crst, 16'h0000);
         host.acc(1'b0, 6'h04, 16'h0000, 1'b0, q);
         chk(q & 16'hfffc, stat(r));
         chk(aen, r[7]);
         chk(sfi, r[8]);
         chk(ofs, r[15:0]);
      end
      v = 16'($random(seed));
      proc.acc(1'b1, 6'h0e, v, 1'b0, q);
      proc.acc(1'b1, 6'h0a, 16'h3d80, 1'b0, q);
      host.acc(1'b0, 6'h0a, 16'h0000, 1'b1, q);
      chk(q[10], 1'b1);
      host.acc(1'b0, 6'h0e, 16'h0000, 1'b1, q);
      chk(q, v);
      host.acc(1'b0, 6'h0a, 16'h0000, 1'b0, q);
      chk(q[10], 1'b0);
      n = 0;
      repeat (6) begin
         proc.acc(1'b1, 6'h0a, 16'h3b80, 1'b0, q);
         v = 16'($random(seed));
         host.send(v, ok, q);
         if (!ok) break;
         sent.push_back(v);
         chk(q[9], 1'b0);
         proc.acc(1'b0, 6'h0e, 16'h0000, 1'b0, q);
         chk(q, v);
         n++;
      end
      // The queue and the command stage hold one word more than the depth.
      chk(16'(n), 16'(vcr_pkg::FIFO_DEPTH + 1));
      chk(16'(ok), 16'h0000);
      t = 0;
      while (sent.size() > 0 && t < 100) begin
         r = $random(seed);
         cmd_ready_i = cv & r[0];
         if (cmd_ready_i) chk(cd, sent.pop_front());
         @(negedge clk_i);
         t++;
      end
      cmd_ready_i = 1'b0;
      if (sent.size() > 0) errors++;
      @(negedge clk_i);
      chk(cv, 1'b0);
      conclude();
   end
endmodule // testbench
